//--- verilog/hic_host.v
// Host-side controller driving the interrupt controller pins, commanded over AXI4-Lite
// Functional notes
// - Host ends each polled service with END_OF_SERVICE_FLAG
// - Three acknowledge pulses call, two vector
// - Peripheral holds line past first acknowledge
// - Unused level seven served by return only; poll close still sends EOI after a polled level seven
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`include "hic_regs.vh"
module hic_host (
   input wire aclk,
   input wire aresetn,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire dev_int,
   input wire [7:0] dev_data_i,
   output wire [7:0] dev_data_o,
   output wire dev_data_oe,
   output wire dev_cs_n,
   output wire dev_a0,
   output wire dev_wr_n,
   output wire dev_rd_n,
   output wire ack_strobe_n
);
   localparam [5:0] M_IDLE = 6'h01;
   localparam [5:0] M_CMD = 6'h02;
   localparam [5:0] M_POLL_WR = 6'h04;
   localparam [5:0] M_POLL_RD = 6'h08;
   localparam [5:0] M_EOI = 6'h10;
   localparam [5:0] M_ACK = 6'h20;

   reg [2:0] ctrl_reg;
   reg [5:0] state_reg;
   reg [10:0] cmd_reg;
   reg cmd_go_reg;
   reg seq_start_reg;
   reg [1:0] seq_kind_reg;
   reg seq_a0_reg;
   reg [7:0] seq_byte_reg;
   reg poll_present_reg;
   reg poll_spurious_reg;
   reg [2:0] poll_level_reg;
   reg [7:0] last_byte_reg;
   reg [23:0] ack_bytes_reg;
   reg [1:0] ack_idx_reg;
   reg int_meta_reg;
   reg int_sync_reg;
   reg [31:0] rd_word;
   reg rd_hit;
   wire seq_done;
   wire [7:0] seq_rbyte;
   wire busy;
   wire wr_hs;
   wire rd_hs;
   wire cmd_hit;
   wire [1:0] ack_last;

   assign busy = (state_reg != M_IDLE) | cmd_go_reg;
   // One write and one read at a time: take a new one only when the answer has gone
   assign wr_hs = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_awready = wr_hs;
   assign s_axi_wready = wr_hs;
   assign rd_hs = s_axi_arvalid & ~s_axi_rvalid;
   assign s_axi_arready = rd_hs;
   assign cmd_hit = (s_axi_awaddr[3:2] == `HIC_OFF_CMD >> 2) & (s_axi_wstrb[1:0] == 2'h3);
   assign ack_last = ctrl_reg[`HIC_CTRL_VECTOR] ? `HIC_ACKS_VECTOR - 2'h1 : `HIC_ACKS_CALL - 2'h1;

   // Interrupt pin is asynchronous to aclk
   always @(posedge aclk) begin
      int_meta_reg <= dev_int;
      int_sync_reg <= int_meta_reg;
   end

   // Register writes; a command while busy is refused with SLVERR and dropped
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= `HIC_CTRL_RESET;
         cmd_reg <= 11'h000;
         cmd_go_reg <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (state_reg == M_IDLE) begin
            cmd_go_reg <= 1'b0;
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_hs) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'h0;
            if (s_axi_awaddr[3:2] == `HIC_OFF_CTRL >> 2) begin
               if (s_axi_wstrb[0]) begin
                  ctrl_reg <= s_axi_wdata[2:0];
               end
            end else if (s_axi_awaddr[3:2] == `HIC_OFF_CMD >> 2) begin
               if (busy) begin
                  s_axi_bresp <= 2'h2;
               end else if (cmd_hit) begin
                  cmd_reg <= s_axi_wdata[10:0];
                  cmd_go_reg <= 1'b1;
               end
            end else if (s_axi_awaddr[3:2] != `HIC_OFF_STATUS >> 2 && s_axi_awaddr[3:2] != `HIC_OFF_DATA >> 2) begin
               s_axi_bresp <= 2'h2;
            end
         end
      end
   end

   // Read mux
   always @* begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      case (s_axi_araddr[3:2])
         2'h0: rd_word[2:0] = ctrl_reg;
         2'h1: rd_word[10:0] = cmd_reg;
         2'h2: begin
            rd_word[`HIC_ST_BUSY] = busy;
            rd_word[`HIC_ST_INT] = int_sync_reg & ~ctrl_reg[`HIC_CTRL_POLL_MODE];
            rd_word[`HIC_ST_PRESENT] = poll_present_reg;
            rd_word[`HIC_ST_SPURIOUS] = poll_spurious_reg;
            rd_word[`HIC_ST_LEVEL_LSB +: 3] = poll_level_reg;
            rd_word[`HIC_ST_BYTE_LSB +: 8] = last_byte_reg;
         end
         2'h3: rd_word[23:0] = ack_bytes_reg;
         default: rd_hit = 1'b0;
      endcase
   end

   // Read answer one cycle after the address is taken
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else if (rd_hs) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Sequence of pin cycles for each command
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= M_IDLE;
         seq_start_reg <= 1'b0;
         seq_kind_reg <= `HIC_KIND_WRITE;
         seq_a0_reg <= 1'b0;
         seq_byte_reg <= 8'h00;
         poll_present_reg <= 1'b0;
         poll_spurious_reg <= 1'b0;
         poll_level_reg <= 3'h0;
         last_byte_reg <= 8'h00;
         ack_bytes_reg <= 24'h000000;
         ack_idx_reg <= 2'h0;
      end else begin
         seq_start_reg <= 1'b0;
         case (state_reg)
            M_IDLE: begin
               if (cmd_go_reg) begin
                  seq_start_reg <= 1'b1;
                  seq_a0_reg <= cmd_reg[`HIC_CMD_A0];
                  seq_byte_reg <= cmd_reg[`HIC_CMD_BYTE_LSB +: 8];
                  ack_idx_reg <= 2'h0;
                  case (cmd_reg[`HIC_CMD_OP_LSB +: 2])
                     `HIC_OP_WRITE: begin
                        seq_kind_reg <= `HIC_KIND_WRITE;
                        state_reg <= M_CMD;
                     end
                     `HIC_OP_READ: begin
                        seq_kind_reg <= `HIC_KIND_READ;
                        state_reg <= M_CMD;
                     end
                     `HIC_OP_POLL: begin
                        // Poll word goes to the third op word address
                        seq_kind_reg <= `HIC_KIND_WRITE;
                        seq_a0_reg <= 1'b0;
                        seq_byte_reg <= `HIC_OPW3_POLL;
                        state_reg <= M_POLL_WR;
                     end
                     default: begin
                        seq_kind_reg <= `HIC_KIND_ACK;
                        ack_bytes_reg <= 24'h000000;
                        state_reg <= M_ACK;
                     end
                  endcase
               end
            end
            M_CMD: begin
               if (seq_done) begin
                  if (seq_kind_reg == `HIC_KIND_READ) begin
                     last_byte_reg <= seq_rbyte;
                  end
                  state_reg <= M_IDLE;
               end
            end
            M_POLL_WR: begin
               // Read follows at once so the frozen window stays short
               if (seq_done) begin
                  seq_start_reg <= 1'b1;
                  seq_kind_reg <= `HIC_KIND_READ;
                  seq_a0_reg <= 1'b0;
                  state_reg <= M_POLL_RD;
               end
            end
            M_POLL_RD: begin
               if (seq_done) begin
                  last_byte_reg <= seq_rbyte;
                  poll_present_reg <= seq_rbyte[`HIC_POLL_PRESENT_BIT];
                  poll_level_reg <= seq_rbyte[2:0];
                  // Level seven may be the default report; software checks in-service
                  poll_spurious_reg <= seq_rbyte[`HIC_POLL_PRESENT_BIT] & (seq_rbyte[2:0] == `HIC_LEVEL_SEVEN);
                  if (seq_rbyte[`HIC_POLL_PRESENT_BIT] & ctrl_reg[`HIC_CTRL_POLL_CLOSE]) begin
                     seq_start_reg <= 1'b1;
                     seq_kind_reg <= `HIC_KIND_WRITE;
                     seq_a0_reg <= 1'b0;
                     seq_byte_reg <= `HIC_OPW2_EOI;
                     state_reg <= M_EOI;
                  end else begin
                     state_reg <= M_IDLE;
                  end
               end
            end
            M_EOI: begin
               if (seq_done) begin
                  state_reg <= M_IDLE;
               end
            end
            M_ACK: begin
               if (seq_done) begin
                  ack_bytes_reg[{ack_idx_reg, 3'h0} +: 8] <= seq_rbyte;
                  last_byte_reg <= seq_rbyte;
                  if (ack_idx_reg == ack_last) begin
                     state_reg <= M_IDLE;
                  end else begin
                     ack_idx_reg <= ack_idx_reg + 2'h1;
                     seq_start_reg <= 1'b1;
                  end
               end
            end
            default: begin
               state_reg <= M_IDLE;
            end
         endcase
      end
   end

   hic_pin_seq u_seq (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(seq_start_reg),
      .kind(seq_kind_reg),
      .a0(seq_a0_reg),
      .wbyte(seq_byte_reg),
      .dev_data_i(dev_data_i),
      .dev_data_o(dev_data_o),
      .dev_data_oe(dev_data_oe),
      .dev_cs_n(dev_cs_n),
      .dev_a0(dev_a0),
      .dev_wr_n(dev_wr_n),
      .dev_rd_n(dev_rd_n),
      .ack_strobe_n(ack_strobe_n),
      .done(seq_done),
      .rbyte_reg(seq_rbyte)
   );
endmodule

//--- verilog/hic_regs.vh
// Register map, field positions and timing figures of the interrupt host controller
`ifndef HIC_REGS_VH
`define HIC_REGS_VH
// Register offsets (byte addresses, one aligned word each)
`define HIC_OFF_CTRL 4'h0
`define HIC_OFF_CMD 4'h4
`define HIC_OFF_STATUS 4'h8
`define HIC_OFF_DATA 4'hC
// CTRL fields
`define HIC_CTRL_VECTOR 0
`define HIC_CTRL_POLL_MODE 1
`define HIC_CTRL_POLL_CLOSE 2
`define HIC_CTRL_RESET 3'h4
// CMD fields
`define HIC_CMD_BYTE_LSB 0
`define HIC_CMD_A0 8
`define HIC_CMD_OP_LSB 9
`define HIC_OP_WRITE 2'h0
`define HIC_OP_READ 2'h1
`define HIC_OP_POLL 2'h2
`define HIC_OP_ACK 2'h3
// STATUS fields
`define HIC_ST_BUSY 0
`define HIC_ST_INT 1
`define HIC_ST_PRESENT 2
`define HIC_ST_SPURIOUS 3
`define HIC_ST_LEVEL_LSB 4
`define HIC_ST_BYTE_LSB 8
// Poll byte layout and fixed command bytes
`define HIC_POLL_PRESENT_BIT 7
`define HIC_OPW3_POLL 8'h0C
`define HIC_OPW2_EOI 8'h20
`define HIC_LEVEL_SEVEN 3'h7
// Pin cycle kinds
`define HIC_KIND_WRITE 2'h0
`define HIC_KIND_READ 2'h1
`define HIC_KIND_ACK 2'h2
// Acknowledge pulses per cycle
`define HIC_ACKS_CALL 2'h3
`define HIC_ACKS_VECTOR 2'h2
// Timing figures
`define HIC_CLK_NS 20
`define HIC_STROBE_NS 160
`define HIC_RECOVER_NS 200
`define HIC_SYNC_CYC 2
`endif

//--- verilog/hic_pin_seq.v
// One strobe cycle on the device pins: write, register read or acknowledge pulse
`timescale 1ns/100ps
`include "hic_regs.vh"
module hic_pin_seq (
   input wire aclk,
   input wire aresetn,
   input wire start,
   input wire [1:0] kind,
   input wire a0,
   input wire [7:0] wbyte,
   input wire [7:0] dev_data_i,
   output reg [7:0] dev_data_o,
   output reg dev_data_oe,
   output reg dev_cs_n,
   output reg dev_a0,
   output reg dev_wr_n,
   output reg dev_rd_n,
   output reg ack_strobe_n,
   output reg done,
   output reg [7:0] rbyte_reg
);
   // Least times round up; the low time also covers the data synchroniser delay
   localparam LOW_CYC = (`HIC_STROBE_NS + `HIC_CLK_NS - 1) / `HIC_CLK_NS + `HIC_SYNC_CYC;
   localparam REC_CYC = (`HIC_RECOVER_NS + `HIC_CLK_NS - 1) / `HIC_CLK_NS;
   localparam [3:0] S_IDLE = 4'h1;
   localparam [3:0] S_SET = 4'h2;
   localparam [3:0] S_LOW = 4'h4;
   localparam [3:0] S_REC = 4'h8;

   reg [3:0] state_reg;
   reg [4:0] cnt_reg;
   reg [1:0] kind_reg;
   reg [7:0] data_meta_reg;
   reg [7:0] data_sync_reg;

   // Data bus comes from another chip, two flops before use
   always @(posedge aclk) begin
      data_meta_reg <= dev_data_i;
      data_sync_reg <= data_meta_reg;
   end

   // Strobe sequencer; every pin is registered so no glitch reaches the device
   // Select, address and data lead each write or read strobe by a cycle and trail it by one, never moving on a strobe edge; acknowledge runs with select high
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= S_IDLE;
         cnt_reg <= 5'h00;
         kind_reg <= 2'h0;
         dev_data_o <= 8'h00;
         dev_data_oe <= 1'b0;
         dev_cs_n <= 1'b1;
         dev_a0 <= 1'b0;
         dev_wr_n <= 1'b1;
         dev_rd_n <= 1'b1;
         ack_strobe_n <= 1'b1;
         done <= 1'b0;
         rbyte_reg <= 8'h00;
      end else begin
         done <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               if (start) begin
                  kind_reg <= kind;
                  cnt_reg <= 5'h00;
                  dev_a0 <= a0;
                  dev_data_o <= wbyte;
                  dev_data_oe <= (kind == `HIC_KIND_WRITE);
                  dev_cs_n <= (kind == `HIC_KIND_ACK);
                  state_reg <= S_SET;
               end
            end
            S_SET: begin
               // Setup cycle done, now the strobe of this kind falls
               dev_wr_n <= ~(kind_reg == `HIC_KIND_WRITE);
               dev_rd_n <= ~(kind_reg == `HIC_KIND_READ);
               ack_strobe_n <= ~(kind_reg == `HIC_KIND_ACK);
               state_reg <= S_LOW;
            end
            S_LOW: begin
               if (cnt_reg == LOW_CYC[4:0] - 5'h01) begin
                  // Sample just before the rising edge, data are settled by then
                  if (kind_reg != `HIC_KIND_WRITE) begin
                     rbyte_reg <= data_sync_reg;
                  end
                  dev_wr_n <= 1'b1;
                  dev_rd_n <= 1'b1;
                  ack_strobe_n <= 1'b1;
                  cnt_reg <= 5'h00;
                  state_reg <= S_REC;
               end else begin
                  cnt_reg <= cnt_reg + 5'h01;
               end
            end
            S_REC: begin
               // Recovery before any next strobe of any kind; select and data let go one cycle in
               dev_cs_n <= 1'b1;
               dev_data_oe <= 1'b0;
               if (cnt_reg == REC_CYC[4:0] - 5'h01) begin
                  done <= 1'b1;
                  state_reg <= S_IDLE;
               end else begin
                  cnt_reg <= cnt_reg + 5'h01;
               end
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end
endmodule

//--- tb/hic_dev_model.sv
// Behavioural model of the interrupt controller device seen on the host pins
`timescale 1ns/100ps
module hic_dev_model (
   input wire cs_n,
   input wire a0,
   input wire wr_n,
   input wire rd_n,
   input wire ack_strobe_n,
   input wire vector_mode,
   input wire [7:0] din,
   input wire [7:0] request_lines,
   output wire dev_int,
   output reg [7:0] dq
);
   reg [7:0] pending_request_bits = 8'h00;
   reg [7:0] in_service_bits = 8'h00;
   reg [7:0] prev = 8'h00;
   reg [7:0] op2 = 8'h00;
   reg [2:0] low = 3'h7;
   reg [1:0] nack = 2'h0;
   reg level_trigger_select = 1'h0;
   reg poll = 1'h0;
   reg frz = 1'h0;
   reg rot_auto = 1'h0;
   reg [3:0] v;
   integer i;
   initial dq = 8'h5A;
   // Highest pending level; an in-service level stops the scan
   function [3:0] pick(input [7:0] rq, input [7:0] sv, input [2:0] lo);
      reg [2:0] l;
      reg stop;
      integer k;
      begin
         pick = 4'h0;
         stop = 1'h0;
         for (k = 1; k <= 8; k = k + 1) begin
            l = lo + k[2:0];
            if (!stop && sv[l]) stop = 1'h1;
            if (!stop && rq[l]) pick = {1'h1, l};
            if (rq[l]) stop = 1'h1;
         end
      end
   endfunction
   assign dev_int = !poll && pick(pending_request_bits, in_service_bits, low) >= 4'h8;
   // Request cells follow the lines unless frozen
   always @(request_lines or frz) begin
      for (i = 0; i < 8; i = i + 1) begin
         if (!frz && (level_trigger_select || !request_lines[i])) pending_request_bits[i] = request_lines[i];
         else if (!frz && !prev[i]) pending_request_bits[i] = request_lines[i];
      end
      if (!frz) prev = request_lines;
   end
   // Command words land on the closing edge of the write strobe
   always @(posedge wr_n) begin
      frz = 1'h0;
      if (!cs_n && !a0 && din[4]) begin
         pending_request_bits = 8'h00;
         in_service_bits = 8'h00;
         low = 3'h7;
         level_trigger_select = din[3];
         poll = 1'h0;
      end else if (!cs_n && !a0 && din[3]) begin
         poll = din[2];
         frz = din[2];
      end else if (!cs_n && !a0) begin
         op2 = din;
         v = din[6] ? {1'h1, din[2:0]} : pick(in_service_bits, 8'h00, low);
         if (din[5] && v[3]) in_service_bits[v[2:0]] = 1'h0;
         if (din[7] && (din[6] || (din[5] && v[3]))) low = v[2:0];
         if (!din[6] && (din[7] ^ din[5])) rot_auto = din[7];
      end
      dq = ~dq;
   end
   // A read after a poll command acts as acknowledge
   always @(negedge rd_n) begin
      if (!cs_n && poll) begin
         v = pick(pending_request_bits, in_service_bits, low);
         dq = {v[3], 4'h0, v[2:0]};
         if (v[3]) in_service_bits[v[2:0]] = 1'h1;
      end else if (!cs_n) dq = in_service_bits;
   end
   always @(posedge rd_n) begin
      poll = 1'h0;
      frz = 1'h0;
      dq = ~dq;
   end
   // First pulse resolves; a dropped line reports the default level seven
   always @(negedge ack_strobe_n) begin
      if (nack == 2'h0) begin
         frz = 1'h1;
         v = pick(pending_request_bits, in_service_bits, low);
         if (v[3]) in_service_bits[v[2:0]] = 1'h1;
         if (v[3] && !level_trigger_select) pending_request_bits[v[2:0]] = 1'h0;
         if (!v[3]) v = 4'h7;
      end
      dq = {5'h10, v[2:0]};
   end
   // Sequence length follows the processor mode
   always @(posedge ack_strobe_n) begin
      nack = nack + 2'h1;
      if (nack == (vector_mode ? 2'h2 : 2'h3)) frz = 1'h0;
      if (!frz) nack = 2'h0;
      dq = ~dq;
   end
endmodule

//--- tb/hic_host_asserts.sv
// Port checker for the interrupt host controller
`timescale 1ns/100ps
module hic_host_checker (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire dev_data_oe,
   input wire dev_cs_n,
   input wire dev_wr_n,
   input wire dev_rd_n,
   input wire ack_strobe_n
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Strobe stays low ten cycles; chip select trails it by one cycle
   sequence wr_tail;
      (!dev_wr_n && !dev_cs_n)[*8] ##1 !dev_wr_n ##1 (dev_wr_n && !dev_cs_n) ##1 (dev_wr_n && dev_cs_n);
   endsequence
   sequence rd_tail;
      (!dev_rd_n && !dev_cs_n)[*8] ##1 !dev_rd_n ##1 (dev_rd_n && !dev_cs_n) ##1 (dev_rd_n && dev_cs_n);
   endsequence
   AST_WR_TAKEN: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
      |-> s_axi_awready && s_axi_wready ##1 s_axi_bvalid) else $error("write not answered");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
   AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rresp == 2'h0)
      else $error("read not answered");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   AST_WR_PULSE: assert property ($fell(dev_wr_n) |-> ##1 wr_tail) else $error("write strobe shape");
   AST_RD_PULSE: assert property ($fell(dev_rd_n) |-> ##1 rd_tail) else $error("read strobe shape");
   AST_OE_WRITE: assert property ((dev_wr_n || dev_data_oe) && (!dev_data_oe || (!dev_cs_n && dev_rd_n)))
      else $error("bus drive outside write");
   AST_ACK_CS: assert property (!ack_strobe_n |-> dev_cs_n && dev_wr_n && dev_rd_n)
      else $error("acknowledge overlaps select");
   AST_ACK_GAP: assert property ($rose(ack_strobe_n) |-> ack_strobe_n[*8])
      else $error("acknowledge recovery short");
endmodule
bind hic_host hic_host_checker u_hic_host_checker (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .dev_data_oe(dev_data_oe), .dev_cs_n(dev_cs_n),
   .dev_wr_n(dev_wr_n), .dev_rd_n(dev_rd_n), .ack_strobe_n(ack_strobe_n));

//--- tb/hic_host_tb.sv
// Self-checking bench for the interrupt host controller against the device model
`timescale 1ns/100ps
module hic_host_tb;
   reg aclk = 1'h0;
   reg aresetn = 1'h0;
   reg [3:0] s_axi_awaddr = 4'h0;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [3:0] s_axi_araddr = 4'h0;
   reg s_axi_awvalid = 1'h0;
   reg s_axi_wvalid = 1'h0;
   reg s_axi_bready = 1'h0;
   reg s_axi_arvalid = 1'h0;
   reg s_axi_rready = 1'h0;
   reg [7:0] req = 8'h00;
   reg vec = 1'h0;
   reg [31:0] st;
   reg [1:0] rs;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire dev_int, dev_data_oe, dev_cs_n, dev_a0, dev_wr_n, dev_rd_n, ack_strobe_n;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [7:0] dev_data_o, dq, bus;
   integer n_fail = 0;
   integer n_compared = 0;
   integer n_ack = 0;
   // Host drives the bus only in its write cycles, otherwise the device model
   assign bus = dev_data_oe ? dev_data_o : dq;
   hic_host u_hic_host (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .dev_int(dev_int), .dev_data_i(bus), .dev_data_o(dev_data_o), .dev_data_oe(dev_data_oe), .dev_cs_n(dev_cs_n),
      .dev_a0(dev_a0), .dev_wr_n(dev_wr_n), .dev_rd_n(dev_rd_n), .ack_strobe_n(ack_strobe_n));
   hic_dev_model u_hic_dev_model (.cs_n(dev_cs_n), .a0(dev_a0), .wr_n(dev_wr_n), .rd_n(dev_rd_n),
      .ack_strobe_n(ack_strobe_n), .vector_mode(vec), .din(bus), .request_lines(req), .dev_int(dev_int), .dq(dq));
   initial forever #10 aclk = ~aclk;
   always @(negedge ack_strobe_n) n_ack = n_ack + 1;
   task close_out;
      begin
         if (n_fail == 0 && n_compared > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   // Address and data offered together, response awaited with bready up
   task axi_wr(input [3:0] ad, input [31:0] d, output [1:0] r);
      begin
         s_axi_awaddr <= ad;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid <= 1'h1;
         s_axi_bready <= 1'h1;
         do @(posedge aclk); while (s_axi_awready !== 1'h1);
         s_axi_awvalid <= 1'h0;
         s_axi_wvalid <= 1'h0;
         do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
         r = s_axi_bresp;
         s_axi_bready <= 1'h0;
         // One edge passes so a following call never raises bready in the same step
         @(posedge aclk);
      end
   endtask
   task axi_rd(input [3:0] ad, output [31:0] d);
      begin
         s_axi_araddr <= ad;
         s_axi_arvalid <= 1'h1;
         s_axi_rready <= 1'h1;
         do @(posedge aclk); while (s_axi_arready !== 1'h1);
         s_axi_arvalid <= 1'h0;
         do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
         d = s_axi_rdata;
         s_axi_rready <= 1'h0;
         @(posedge aclk);
      end
   endtask
   task idle;
      begin
         axi_rd(4'h8, st);
         while (st[0] !== 1'h0) axi_rd(4'h8, st);
      end
   endtask
   task cmd(input [1:0] op, input a, input [7:0] b);
      begin
         axi_wr(4'h4, {21'h0, op, a, b}, rs);
         idle;
      end
   endtask
   task poll_chk(input [2:0] lvl);
      begin
         cmd(2'h2, 1'h0, 8'h00);
         axi_rd(4'h8, st);
         chk({st[15:8], st[6:4], st[2]}, {1'h1, 4'h0, lvl, lvl, 1'h1});
      end
   endtask
   task t_reset_busy;
      begin
         axi_rd(4'h0, st);
         chk(st, 32'h4);
         axi_wr(4'h4, 32'h10, rs);
         axi_wr(4'h4, 32'h10, rs);
         chk(rs, 2'h2);
         idle;
      end
   endtask
   task t_int_poll;
      begin
         axi_wr(4'h0, 32'h4, rs);
         cmd(2'h0, 1'h0, 8'h10);
         req <= 8'h08;
         repeat (6) @(posedge aclk);
         axi_rd(4'h8, st);
         chk(st[1], 1'h1);
         axi_wr(4'h0, 32'h6, rs);
         axi_rd(4'h8, st);
         chk(st[1], 1'h0);
         poll_chk(3'h3);
         chk({u_hic_dev_model.op2, u_hic_dev_model.in_service_bits}, 32'h2000);
      end
   endtask
   // Level mode keeps lines 2 and 4 asserted while priorities turn
   task t_rotate;
      begin
         axi_wr(4'h0, 32'h2, rs);
         cmd(2'h0, 1'h0, 8'h18);
         req <= 8'h14;
         poll_chk(3'h2);
         cmd(2'h0, 1'h0, 8'hA0);
         poll_chk(3'h4);
         cmd(2'h0, 1'h0, 8'hE4);
         poll_chk(3'h2);
         cmd(2'h0, 1'h0, 8'hC2);
         poll_chk(3'h4);
         // Plain register read: levels 2 and 4 both still in service
         cmd(2'h1, 1'h0, 8'h00);
         axi_rd(4'h8, st);
         chk(st[15:8], 8'h14);
      end
   endtask
   // Acknowledge cycle; drop pulls the line before the first pulse
   task t_ack(input v, input [7:0] r, input drop, input s7);
      begin
         vec <= v;
         axi_wr(4'h0, {31'h2, v}, rs);
         cmd(2'h0, 1'h0, 8'h10);
         req <= 8'h00;
         @(posedge aclk);
         req <= r;
         @(posedge aclk);
         if (drop) req <= 8'h00;
         n_ack = 0;
         cmd(2'h3, 1'h0, 8'h00);
         axi_rd(4'hC, st);
         chk(st[7:0], 8'h87);
         chk(u_hic_dev_model.in_service_bits[7], s7);
         chk(n_ack, v ? 2 : 3);
      end
   endtask
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset_busy;
      t_int_poll;
      t_rotate;
      t_ack(1'h0, 8'h04, 1'h1, 1'h0);
      t_ack(1'h1, 8'h80, 1'h0, 1'h1);
      close_out;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      n_fail = n_fail + 1;
      close_out;
   end
endmodule
